// ===== common/fpec_params.svh
// Constants for the flash program/erase control block.
// Assumes inclusion by the package and the design files; definitions only.
`ifndef FPEC_PARAMS_SVH
`define FPEC_PARAMS_SVH

// ****************************************
// Register addresses
// ****************************************
`define FPEC_ADDR_CTRL        4'h0
`define FPEC_ADDR_KEY         4'h1
`define FPEC_ADDR_LATCH_LO    4'h2
`define FPEC_ADDR_LATCH_HI    4'h3
`define FPEC_ADDR_LATCH_IDX   4'h4

// ****************************************
// Control register fields
// ****************************************
`define FPEC_BIT_START        15
`define FPEC_BIT_WRITE_ENABLE_BIT         14
`define FPEC_BIT_SEQERR       13
`define FPEC_BIT_ERASE        6
`define FPEC_OP_MSB           3
`define FPEC_CTRL_RESET       16'h0000

// ****************************************
// Unlock keys and operation codes
// ****************************************
`define FPEC_KEY_FIRST        8'h55
`define FPEC_KEY_SECOND       8'hAA
`define FPEC_OP_BULK          4'hF
`define FPEC_OP_GEN_SEG       4'hD
`define FPEC_OP_SEC_SEG       4'hC
`define FPEC_OP_WORD          4'h3
`define FPEC_OP_PAGE          4'h2
`define FPEC_OP_ROW           4'h1
`define FPEC_OP_CFG_BYTE      4'h0

// ****************************************
// Timing
// ****************************************
`define FPEC_CLK_MHZ          50
`define FPEC_PROG_TIME_US     20
`define FPEC_ERASE_TIME_US    200
`define FPEC_UNLOCK_WINDOW    8'h04

`endif

// ===== common/fpec_pkg.sv
// Types shared by the flash program/erase control block.
// Assumes fpec_params.svh is reachable on the include path.
package fpec_pkg;
`include "fpec_params.svh"

   typedef enum logic [3:0] {
      FPEC_ACT_NONE  = 4'h0,
      FPEC_ACT_PROG  = 4'h1,
      FPEC_ACT_ERASE = 4'h2,
      FPEC_ACT_CFG   = 4'h3
   } fpec_action_t;

   typedef enum logic [3:0] {
      FPEC_TGT_NONE  = 4'h0,
      FPEC_TGT_WORD  = 4'h1,
      FPEC_TGT_ROW   = 4'h2,
      FPEC_TGT_PAGE  = 4'h3,
      FPEC_TGT_BULK  = 4'h4,
      FPEC_TGT_GSEG  = 4'h5,
      FPEC_TGT_SSEG  = 4'h6,
      FPEC_TGT_CBYTE = 4'h7
   } fpec_target_t;

   typedef struct packed {
      fpec_action_t action;
      fpec_target_t target;
   } fpec_decode_t;

   typedef struct packed {
      logic         valid;
      fpec_action_t action;
      fpec_target_t target;
      logic [23:0]  addr;
   } fpec_cmd_t;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } fpec_bus_req_t;
endpackage

// ===== hdl/fpec_op_decode.sv
// Operation decoder: maps the operation code and erase select to an action.
// Assumes purely combinational use inside the controller.
`include "fpec_params.svh"
module fpec_op_decode
   import fpec_pkg::*;
(
   input  wire logic [3:0]            op_code_in,
   input  wire logic                  erase_sel_in,
   output fpec_pkg::fpec_decode_t     decode_out
);
   import fpec_pkg::*;

   // ****************************************
   // Code table; reserved codes fall to no action
   // ****************************************
   wire         is_bulk  = (op_code_in == `FPEC_OP_BULK) && erase_sel_in;
   wire         is_gseg  = (op_code_in == `FPEC_OP_GEN_SEG) && erase_sel_in;
   wire         is_sseg  = (op_code_in == `FPEC_OP_SEC_SEG) && erase_sel_in;
   wire         is_word  = (op_code_in == `FPEC_OP_WORD) && !erase_sel_in;
   wire         is_page  = (op_code_in == `FPEC_OP_PAGE) && erase_sel_in;
   wire         is_row   = (op_code_in == `FPEC_OP_ROW) && !erase_sel_in;
   wire         is_cbyte = (op_code_in == `FPEC_OP_CFG_BYTE);

   // Anything else, including 1110 and 0100..1011, yields no action
   assign decode_out.target = is_bulk  ? FPEC_TGT_BULK  :
                              is_gseg  ? FPEC_TGT_GSEG  :
                              is_sseg  ? FPEC_TGT_SSEG  :
                              is_word  ? FPEC_TGT_WORD  :
                              is_page  ? FPEC_TGT_PAGE  :
                              is_row   ? FPEC_TGT_ROW   :
                              is_cbyte ? FPEC_TGT_CBYTE : FPEC_TGT_NONE;

   assign decode_out.action = is_cbyte ? FPEC_ACT_CFG :
                              (is_bulk | is_gseg | is_sseg | is_page) ? FPEC_ACT_ERASE :
                              (is_word | is_row) ? FPEC_ACT_PROG : FPEC_ACT_NONE;

endmodule // fpec_op_decode

// ===== hdl/fpec_ctrl.sv
// Flash program/erase controller: control, key and latch registers, unlock
// sequencing and a self-timed operation timer.
// Assumes a single 50 MHz clock, a plain register port and a flash array
// outside that accepts a one-cycle command pulse.
//
// Implementation choices: the strobed register port and the address map.
`include "fpec_params.svh"
module fpec_ctrl
   import fpec_pkg::*;
#(
   parameter int PROG_CYCLES  = `FPEC_PROG_TIME_US * `FPEC_CLK_MHZ,
   parameter int ERASE_CYCLES = `FPEC_ERASE_TIME_US * `FPEC_CLK_MHZ,
   parameter int LATCH_DEPTH  = 64
)
(
   input  wire logic                  clk_sys_in,
   input  wire logic                  rst_in,
   input  wire logic                  por_in,
   input  wire logic [3:0]            reg_addr_in,
   input  wire logic [15:0]           reg_wdata_in,
   input  wire logic                  reg_wr_in,
   input  wire logic                  reg_rd_in,
   output logic [15:0]                reg_rdata_out,
   output fpec_pkg::fpec_cmd_t        flash_cmd_out,
   output logic [23:0]                latch_data_out,
   output logic                       busy_out
);
   import fpec_pkg::*;

   localparam int IDX_W = $clog2(LATCH_DEPTH);
   localparam int CNT_W = 24;

   typedef enum logic [2:0] {
      FPEC_ST_IDLE = 3'b001,
      FPEC_ST_RUN  = 3'b010,
      FPEC_ST_DONE = 3'b100
   } fpec_state_t;

   typedef enum logic [2:0] {
      FPEC_KEY_IDLE  = 3'b001,
      FPEC_KEY_HALF  = 3'b010,
      FPEC_KEY_OPEN  = 3'b100
   } fpec_key_t;

   // ****************************************
   // Registers
   // ****************************************
   fpec_state_t          state_q, state_d;
   fpec_key_t            key_q, key_d;
   logic                 start_q, start_d;
   logic                 write_enable_bit_q;
   logic                 seqerr_q, seqerr_d;
   logic                 erase_q;
   logic [3:0]           op_q;
   logic [7:0]           win_q, win_d;
   logic [CNT_W-1:0]     cnt_q, cnt_d;
   logic [IDX_W-1:0]     idx_q;
   logic [15:0]          rdata_q;
   logic [23:0]          latch_q [LATCH_DEPTH];
   fpec_cmd_t            cmd_q, cmd_d;
   fpec_decode_t         decode;

   // A start write may carry new fields; decode what that same write selects
   wire       cfg_now   = reg_wr_in && (reg_addr_in == `FPEC_ADDR_CTRL) && (state_q == FPEC_ST_IDLE);
   wire [3:0] op_eff    = cfg_now ? reg_wdata_in[`FPEC_OP_MSB:0] : op_q;
   wire       erase_eff = cfg_now ? reg_wdata_in[`FPEC_BIT_ERASE] : erase_q;

   fpec_op_decode u_decode (
      .op_code_in   (op_eff),
      .erase_sel_in (erase_eff),
      .decode_out   (decode)
   );

   // ****************************************
   // Register port decode
   // ****************************************
   wire wr_ctrl   = reg_wr_in && (reg_addr_in == `FPEC_ADDR_CTRL);
   wire wr_key    = reg_wr_in && (reg_addr_in == `FPEC_ADDR_KEY);
   wire wr_lat_lo = reg_wr_in && (reg_addr_in == `FPEC_ADDR_LATCH_LO);
   wire wr_lat_hi = reg_wr_in && (reg_addr_in == `FPEC_ADDR_LATCH_HI);
   wire wr_idx    = reg_wr_in && (reg_addr_in == `FPEC_ADDR_LATCH_IDX);
   wire idle      = (state_q == FPEC_ST_IDLE);
   // Start request is a write of one to the start bit; a zero is ignored
   wire start_try = wr_ctrl && reg_wdata_in[`FPEC_BIT_START];
   wire start_req = start_try && !start_q;
   wire unlocked  = (key_q == FPEC_KEY_OPEN);
   // Any write other than the start write itself closes the unlock window
   wire key_break = reg_wr_in && !wr_key && !start_req;
   // The enable written alongside start is the one that counts
   wire launch_ok = start_req && unlocked && reg_wdata_in[`FPEC_BIT_WRITE_ENABLE_BIT] && idle;
   // Config fields stay frozen while an operation runs, so it cannot be retargeted
   wire cfg_wr    = wr_ctrl && idle;
   wire is_erase  = (decode.action == FPEC_ACT_ERASE);
   wire [CNT_W-1:0] op_len = is_erase ? CNT_W'(ERASE_CYCLES) : CNT_W'(PROG_CYCLES);

   wire [15:0] ctrl_view = {start_q, write_enable_bit_q, seqerr_q, 6'h00, erase_q, 2'h0, op_q};
   wire [15:0] rd_mux    = (reg_addr_in == `FPEC_ADDR_CTRL)      ? ctrl_view :
                           (reg_addr_in == `FPEC_ADDR_LATCH_IDX) ? 16'(idx_q) :
                           (reg_addr_in == `FPEC_ADDR_LATCH_LO)  ? latch_q[idx_q][15:0] :
                           (reg_addr_in == `FPEC_ADDR_LATCH_HI)  ? {8'h00, latch_q[idx_q][23:16]} :
                           16'h0000;

   // ****************************************
   // Unlock sequencer
   // ****************************************
   always_comb begin
      key_d = key_q;
      win_d = win_q;
      unique case (key_q)
         FPEC_KEY_IDLE: begin
            if (wr_key && reg_wdata_in[7:0] == `FPEC_KEY_FIRST) begin
               key_d = FPEC_KEY_HALF;
            end
         end
         FPEC_KEY_HALF: begin
            if (wr_key && reg_wdata_in[7:0] == `FPEC_KEY_SECOND) begin
               key_d = FPEC_KEY_OPEN;
               win_d = `FPEC_UNLOCK_WINDOW;
            end else if (wr_key || key_break) begin
               key_d = FPEC_KEY_IDLE;
            end
         end
         FPEC_KEY_OPEN: begin
            // Unlock lasts only a few cycles so a stray later write cannot start
            if (start_req || key_break || wr_key || win_q == 8'h00) begin
               key_d = FPEC_KEY_IDLE;
            end else begin
               win_d = win_q - 8'h01;
            end
         end
      endcase
   end

   // ****************************************
   // Operation sequencer
   // ****************************************
   always_comb begin
      state_d  = state_q;
      start_d  = start_q;
      seqerr_d = seqerr_q;
      cnt_d    = cnt_q;
      cmd_d    = '0;
      unique case (state_q)
         FPEC_ST_IDLE: begin
            if (start_q) begin
               // Sequencer reset cut an operation short: release start, flag it
               start_d  = 1'b0;
               seqerr_d = 1'b1;
            end else if (start_req) begin
               if (launch_ok) begin
                  start_d  = 1'b1;
                  seqerr_d = 1'b0;
                  state_d  = FPEC_ST_RUN;
                  cnt_d    = op_len;
                  cmd_d.valid  = (decode.action != FPEC_ACT_NONE);
                  cmd_d.action = decode.action;
                  cmd_d.target = decode.target;
                  cmd_d.addr   = 24'(idx_q);
               end else begin
                  seqerr_d = 1'b1;
               end
            end
         end
         FPEC_ST_RUN: begin
            if (!write_enable_bit_q) begin
               // Write enable dropped mid-operation: abort and flag it
               seqerr_d = 1'b1;
               state_d  = FPEC_ST_DONE;
            end else if (cnt_q == '0) begin
               if (start_try) begin
                  seqerr_d = 1'b1;
               end
               state_d = FPEC_ST_DONE;
            end else begin
               cnt_d = cnt_q - CNT_W'(1);
               if (start_try) begin
                  seqerr_d = 1'b1;
               end
            end
         end
         FPEC_ST_DONE: begin
            start_d = 1'b0;
            state_d = FPEC_ST_IDLE;
         end
      endcase
   end

   // ****************************************
   // Control bits: cleared only by power-on reset
   // ****************************************
   always_ff @(posedge clk_sys_in) begin
      if (por_in) begin
         start_q  <= 1'b0;
         write_enable_bit_q   <= 1'b0;
         seqerr_q <= 1'b0;
         erase_q  <= 1'b0;
         op_q     <= 4'h0;
      end else begin
         start_q  <= start_d;
         seqerr_q <= seqerr_d;
         if (wr_ctrl) begin
            write_enable_bit_q <= reg_wdata_in[`FPEC_BIT_WRITE_ENABLE_BIT];
         end
         if (cfg_wr) begin
            erase_q <= reg_wdata_in[`FPEC_BIT_ERASE];
            op_q    <= reg_wdata_in[`FPEC_OP_MSB:0];
         end
      end
   end

   // ****************************************
   // Sequencer state: any reset returns it to idle
   // ****************************************
   always_ff @(posedge clk_sys_in) begin
      if (rst_in || por_in) begin
         state_q <= FPEC_ST_IDLE;
         key_q   <= FPEC_KEY_IDLE;
         win_q   <= 8'h00;
         cnt_q   <= '0;
         cmd_q   <= '0;
         rdata_q <= 16'h0000;
         idx_q   <= '0;
      end else begin
         state_q <= state_d;
         key_q   <= key_d;
         win_q   <= win_d;
         cnt_q   <= cnt_d;
         cmd_q   <= cmd_d;
         rdata_q <= reg_rd_in ? rd_mux : 16'h0000;
         if (wr_idx) begin
            idx_q <= reg_wdata_in[IDX_W-1:0];
         end else if (wr_lat_hi) begin
            // High byte write advances the pointer, like a post-increment
            idx_q <= idx_q + IDX_W'(1);
         end
      end
   end

   // ****************************************
   // Program write latches
   // ****************************************
   always_ff @(posedge clk_sys_in) begin
      if (wr_lat_lo) begin
         latch_q[idx_q][15:0] <= reg_wdata_in;
      end
      if (wr_lat_hi) begin
         latch_q[idx_q][23:16] <= reg_wdata_in[7:0];
      end
   end

   assign reg_rdata_out  = rdata_q;
   assign flash_cmd_out  = cmd_q;
   assign latch_data_out = latch_q[cmd_q.addr[IDX_W-1:0]];
   assign busy_out       = start_q;

endmodule // fpec_ctrl

// ===== tb/fpec_ctrl_checker.sv
// Port assertions for the flash program/erase controller.
// Assumes it is bound onto fpec_ctrl and sees only that module's ports.
`include "fpec_params.svh"
module fpec_ctrl_checker
   import fpec_pkg::*;
#(
   parameter int PROG_CYCLES  = 5,
   parameter int ERASE_CYCLES = 9
)
(
   input wire logic                clk_sys_in,
   input wire logic                rst_in,
   input wire logic                por_in,
   input wire logic [3:0]          reg_addr_in,
   input wire logic [15:0]         reg_wdata_in,
   input wire logic                reg_wr_in,
   input wire logic                reg_rd_in,
   input wire logic [15:0]         reg_rdata_out,
   input wire fpec_pkg::fpec_cmd_t flash_cmd_out,
   input wire logic [23:0]         latch_data_out,
   input wire logic                busy_out
);
   // ***
   // Helper logic
   // ***
   localparam int MAX_BUSY = ERASE_CYCLES + 4;
   wire logic       key_wr   = reg_wr_in && reg_addr_in == `FPEC_ADDR_KEY;
   wire logic       ctrl_wr  = reg_wr_in && reg_addr_in == `FPEC_ADDR_CTRL;
   wire logic       start_wr = ctrl_wr && reg_wdata_in[15];
   logic      [2:0] key_age_q;
   logic      [2:0] key_age_d;
   // Saturates so a start long after any key write is seen as unkeyed
   assign key_age_d = key_wr ? 3'h0 : (key_age_q == 3'h7 ? key_age_q : key_age_q + 3'h1);
   always_ff @(posedge clk_sys_in) begin
      key_age_q <= (rst_in || por_in) ? 3'h7 : key_age_d;
   end
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in || por_in);
   // ***
   // Assertions
   // ***
   a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
      else $error("read data not zero outside a read");
   a_cmd_pulse: assert property (flash_cmd_out.valid |=> !flash_cmd_out.valid)
      else $error("command pulse longer than one cycle");
   a_cmd_after_start: assert property (flash_cmd_out.valid |-> busy_out && $past(start_wr))
      else $error("command not one cycle after start");
   a_op_ends: assert property ($rose(busy_out) |-> ##[1:MAX_BUSY] !busy_out)
      else $error("operation never finished");
   a_unlock_launch: assert property (key_wr && reg_wdata_in == 16'h0055 ##1
      key_wr && reg_wdata_in == 16'h00AA ##1 start_wr && reg_wdata_in[14] && !busy_out |=> busy_out)
      else $error("keyed start did not launch");
   a_no_key_refuse: assert property (start_wr && key_age_q >= 3'h6 && !busy_out |=>
      !busy_out && !flash_cmd_out.valid)
      else $error("unkeyed start launched");
   a_write_enable_bit_gate: assert property (start_wr && !reg_wdata_in[14] && !busy_out |=> !busy_out)
      else $error("start without write enable launched");
   a_start_sticky: assert property ($rose(busy_out) && ctrl_wr && !reg_wdata_in[15] |=> busy_out)
      else $error("software cleared the start bit");
   a_cmd_action: assert property (flash_cmd_out.valid |-> flash_cmd_out.action != FPEC_ACT_NONE)
      else $error("command issued with no action");
   c_cmd: cover property (flash_cmd_out.valid);
   c_done: cover property ($fell(busy_out));
   c_refused: cover property (start_wr && key_age_q >= 3'h6);
endmodule // fpec_ctrl_checker

bind fpec_ctrl fpec_ctrl_checker #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_fpec_ctrl_checker (
   .clk_sys_in(clk_sys_in), .rst_in(rst_in), .por_in(por_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
   .flash_cmd_out(flash_cmd_out), .latch_data_out(latch_data_out), .busy_out(busy_out));

// ===== tb/tb_top.sv
// Self-checking bench for the flash program/erase controller.
// Assumes fpec_pkg and the checker are compiled first.
`include "fpec_params.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
   $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import fpec_pkg::*;
   logic        clk_sys_in = 1'b0;
   logic        rst_in     = 1'b1;
   logic        por_in     = 1'b1;
   logic [3:0]  reg_addr_in  = 4'h0;
   logic [15:0] reg_wdata_in = 16'h0000;
   logic        reg_wr_in  = 1'b0;
   logic        reg_rd_in  = 1'b0;
   logic [15:0] reg_rdata_out;
   fpec_cmd_t   flash_cmd_out;
   logic [23:0] latch_data_out;
   logic        busy_out;
   logic        rd_p = 1'b0;
   logic [15:0] rd_q[$];
   logic [7:0]  cmd_q[$];
   logic [31:0] rnd = 32'h325F;
   logic [23:0] lat0 = 24'h000000;
   int          n_errors = 0;
   int          compares = 0;

   fpec_ctrl #(.PROG_CYCLES(5), .ERASE_CYCLES(9), .LATCH_DEPTH(64)) u_fpec_ctrl (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .por_in(por_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .flash_cmd_out(flash_cmd_out), .latch_data_out(latch_data_out),
      .busy_out(busy_out));

   initial begin
      forever #10 clk_sys_in = ~clk_sys_in;
   end

   // ***
   // Helpers
   // ***
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] exp_dec(input logic [3:0] c, input logic e);
      case ({e, c})
         5'h1F:        return {FPEC_ACT_ERASE, FPEC_TGT_BULK};
         5'h1D:        return {FPEC_ACT_ERASE, FPEC_TGT_GSEG};
         5'h1C:        return {FPEC_ACT_ERASE, FPEC_TGT_SSEG};
         5'h03:        return {FPEC_ACT_PROG, FPEC_TGT_WORD};
         5'h12:        return {FPEC_ACT_ERASE, FPEC_TGT_PAGE};
         5'h01:        return {FPEC_ACT_PROG, FPEC_TGT_ROW};
         5'h00, 5'h10: return {FPEC_ACT_CFG, FPEC_TGT_CBYTE};
         default:      return 8'h00;
      endcase
   endfunction
   task idle(input int n);
      reg_wr_in <= 1'b0;
      reg_rd_in <= 1'b0;
      repeat (n) @(posedge clk_sys_in);
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      reg_wr_in    <= 1'b1;
      reg_rd_in    <= 1'b0;
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      @(posedge clk_sys_in);
   endtask
   task rd(input logic [3:0] a, input logic [15:0] e);
      rd_q.push_back(e);
      reg_wr_in   <= 1'b0;
      reg_rd_in   <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_sys_in);
   endtask
   task keys();
      wr(`FPEC_ADDR_KEY, 16'h0055);
      wr(`FPEC_ADDR_KEY, 16'h00AA);
   endtask
   task wait_idle();
      idle(2);
      repeat (40) begin
         @(negedge clk_sys_in);
         if (busy_out !== 1'b1) break;
         @(posedge clk_sys_in);
      end
      @(negedge clk_sys_in);
      `CHK("busy_done", 1'b0, busy_out)
      @(posedge clk_sys_in);
   endtask
   // Key mode 0 skips the keys, 2 sends them in the wrong order
   task op(input logic [3:0] c, input logic e, input logic w, input int km);
      logic ok;
      ok = w && km == 1;
      if (km == 1) keys();
      if (km == 2) begin
         wr(`FPEC_ADDR_KEY, 16'h00AA);
         wr(`FPEC_ADDR_KEY, 16'h0055);
      end
      if (ok && exp_dec(c, e) != 8'h00) cmd_q.push_back(exp_dec(c, e));
      wr(`FPEC_ADDR_CTRL, {1'b1, w, 7'h00, e, 2'b00, c});
      wait_idle();
      rd(`FPEC_ADDR_CTRL, {1'b0, w, !ok, 6'h00, e, 2'b00, c});
   endtask
   task pulse(input logic p);
      if (p) por_in <= 1'b1;
      else rst_in <= 1'b1;
      idle(2);
      rst_in <= 1'b0;
      por_in <= 1'b0;
   endtask
   task finish_test();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // ***
   // Output monitor
   // ***
   always @(posedge clk_sys_in) begin : mon
      logic [15:0] er;
      logic [7:0]  ec;
      if (rd_p) begin
         er = rd_q.size() ? rd_q.pop_front() : 16'hDEAD;
         `CHK("rdata", er, reg_rdata_out)
      end
      rd_p = reg_rd_in;
      if (flash_cmd_out.valid === 1'b1) begin
         ec = cmd_q.size() ? cmd_q.pop_front() : 8'hFF;
         `CHK("cmd", ec, {flash_cmd_out.action, flash_cmd_out.target})
      end
   end

   initial begin
      repeat (5000) @(posedge clk_sys_in);
      n_errors++;
      finish_test();
   end

   // ***
   // Main sequence
   // ***
   initial begin
      idle(2);
      rst_in <= 1'b0;
      por_in <= 1'b0;
      rd(`FPEC_ADDR_CTRL, 16'h0000);
      rd(4'hF, 16'h0000);
      rd(4'h5, 16'h0000);
      repeat (4) begin
         rnd = lfsr(rnd);
         wr(`FPEC_ADDR_CTRL, rnd[15:0] & 16'h404F);
         rd(`FPEC_ADDR_CTRL, rnd[15:0] & 16'h404F);
      end
      wr(`FPEC_ADDR_CTRL, 16'h4001);
      for (int i = 0; i < 3; i++) begin
         rnd = lfsr(rnd);
         if (i == 0) lat0 = rnd[23:0];
         wr(`FPEC_ADDR_LATCH_LO, rnd[15:0]);
         wr(`FPEC_ADDR_LATCH_HI, {8'h00, rnd[23:16]});
      end
      rd(`FPEC_ADDR_LATCH_IDX, 16'h0003);
      `CHK("latch", lat0, latch_data_out)
      keys();
      cmd_q.push_back({FPEC_ACT_PROG, FPEC_TGT_ROW});
      wr(`FPEC_ADDR_CTRL, 16'hC001);
      wr(`FPEC_ADDR_CTRL, 16'h4001);
      keys();
      wr(`FPEC_ADDR_CTRL, 16'hC001);
      wait_idle();
      rd(`FPEC_ADDR_CTRL, 16'h6001);
      op(4'h1, 1'b0, 1'b1, 0);
      op(4'h1, 1'b0, 1'b1, 2);
      op(4'h3, 1'b0, 1'b0, 1);
      for (int e = 0; e < 2; e++) begin
         for (int c = 0; c < 16; c++) op(c[3:0], e[0], 1'b1, 1);
      end
      wr(`FPEC_ADDR_CTRL, 16'h4042);
      pulse(1'b0);
      rd(`FPEC_ADDR_CTRL, 16'h4042);
      pulse(1'b1);
      rd(`FPEC_ADDR_CTRL, 16'h0000);
      idle(3);
      `CHK("cmd_left", 0, cmd_q.size())
      finish_test();
   end
endmodule // tb_top
